/* rtl/nhp_host_port.sv */
`timescale 1ns/1ps
// Functional notes
// - Control byte selects send, poll, read, reset.
// - Deselected: ignore input, serial output released.
// - Flag bit 3 means response readable.
// - Flag bit 2 means command accepted.
// - Both data lines sampled on rising clock.
// - Bytes travel most significant bit first.
// - Poll keeps returning current flag byte.
// - Exchange is send, poll, then read.
// - First command accepted without flag check.
// - Read returns result, length, then payload.
// - Reset byte enters wait until wake low.
// - Serial reset starts when select rises.
// - Interrupt low from ready until response read.
// - Frames are code, length, then payload.
// - One-byte fields, payload up to 253.
// - Echo is one byte without length.
// - Codes 01, 02, 03 classified.
// - Codes 05, 06, 07 classified.
// - Codes 08, 09, 0D, 55; others reserved.
// - Wait-event states block all serial traffic.
module nhp_host_port
    import nhp_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic spi_sck_i,
    input wire logic spi_mosi_i,
    input wire logic host_sel_n_i,
    input wire logic wake_n_i,
    input wire logic sleep_i,
    input wire logic reply_ready_i,
    input wire nhp_resp_s resp_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_o,
    output logic reply_irq_n_o,
    output nhp_cmd_byte_s cmd_o,
    output logic cmd_valid_o,
    output nhp_cmd_e cmd_kind_o,
    output logic resp_take_o,
    output logic ctrl_reset_o,
    output logic wait_state_o
);

    logic sck_s1, sck_s2, sck_d;
    logic mosi_s1, mosi_s2;
    logic sel_s1, sel_s2, sel_d;
    logic wake_s1, wake_s2;
    logic sck_rise, sck_fall, sel_rise, active;
    logic [2:0] bit_cnt;
    logic [6:0] rx_sh;
    logic [7:0] rx_byte;
    logic byte_done;
    nhp_state_e state, next_state;
    logic [7:0] idx, frame_len, read_len;
    logic can_send, read_done, frame_last;
    logic load;
    logic [7:0] next_tx, tx_sh, flags;

    function automatic nhp_cmd_e classify(input logic [7:0] code);
        case (code)
            CODE_IDENTIFY: classify = CMD_IDENTIFY;
            CODE_PROTOCOL: classify = CMD_PROTOCOL;
            CODE_PRESENCE: classify = CMD_PRESENCE;
            CODE_LISTEN: classify = CMD_LISTEN;
            CODE_TRANSMIT: classify = CMD_TRANSMIT;
            CODE_WAIT_EVENT: classify = CMD_WAIT_EVENT;
            CODE_FETCH: classify = CMD_FETCH;
            CODE_STORE: classify = CMD_STORE;
            CODE_FILTER: classify = CMD_FILTER;
            CODE_ECHO: classify = CMD_ECHO;
            default: classify = CMD_RESERVED;
        endcase
    endfunction

    // The serial clock is slow against mclk, so the serial pins and wake go through two stages.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {sck_s1, sck_s2, sck_d} <= 3'h0;
            {mosi_s1, mosi_s2} <= 2'h0;
            {sel_s1, sel_s2, sel_d} <= 3'h7;
            {wake_s1, wake_s2} <= 2'h3;
        end else begin
            sck_s1 <= spi_sck_i;
            sck_s2 <= sck_s1;
            sck_d <= sck_s2;
            mosi_s1 <= spi_mosi_i;
            mosi_s2 <= mosi_s1;
            sel_s1 <= host_sel_n_i;
            sel_s2 <= sel_s1;
            sel_d <= sel_s2;
            wake_s1 <= wake_n_i;
            wake_s2 <= wake_s1;
        end
    end

    assign active = !sel_s2 && !wait_state_o && !sleep_i;
    assign sck_rise = sck_s2 && !sck_d;
    assign sck_fall = !sck_s2 && sck_d;
    assign sel_rise = sel_s2 && !sel_d;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bit_cnt <= 3'h0;
            rx_sh <= 7'h00;
        end else if (!active) begin
            bit_cnt <= 3'h0;
            rx_sh <= 7'h00;
        end else if (sck_rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            rx_sh <= {rx_sh[5:0], mosi_s2};
        end
    end

    assign rx_byte = {rx_sh, mosi_s2};
    assign byte_done = active && sck_rise && (bit_cnt == LAST_BIT);

    always_comb begin
        next_state = state;
        if (!active) begin
            next_state = ST_CTRL;
        end else if (byte_done) begin
            case (state)
                ST_CTRL: begin
                    case (rx_byte)
                        CTRL_SEND: next_state = ST_SEND;
                        CTRL_RESET: next_state = ST_RESET;
                        CTRL_READ: next_state = ST_READ;
                        CTRL_POLL: next_state = ST_POLL;
                        default: next_state = ST_IGNORE;
                    endcase
                end
                ST_SEND: next_state = frame_last ? ST_IGNORE : ST_SEND;
                default: next_state = state;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= ST_CTRL;
        end else begin
            state <= next_state;
        end
    end

    always_comb begin
        frame_last = 1'b0;
        if (idx == IDX_RESET) begin
            frame_last = (rx_byte == CODE_ECHO);
        end else if (idx == IDX_LEN) begin
            frame_last = (rx_byte == 8'h00);
        end else begin
            frame_last = (idx - IDX_LEN) >= frame_len;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmd_o <= '0;
            cmd_valid_o <= 1'b0;
            cmd_kind_o <= CMD_RESERVED;
            frame_len <= 8'h00;
        end else begin
            cmd_valid_o <= byte_done && (state == ST_SEND);
            if (byte_done && (state == ST_SEND)) begin
                cmd_o <= '{first: (idx == IDX_RESET), last: frame_last, data: rx_byte};
                if (idx == IDX_RESET) begin
                    cmd_kind_o <= classify(rx_byte);
                end
                if (idx == IDX_LEN) begin
                    frame_len <= (rx_byte > MAX_PAYLOAD) ? MAX_PAYLOAD : rx_byte;
                end
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            idx <= IDX_RESET;
            read_len <= 8'h00;
        end else if (!active || (byte_done && (state == ST_CTRL))) begin
            idx <= IDX_RESET;
        end else if (byte_done) begin
            idx <= idx + 8'h01;
            if ((state == ST_READ) && (idx == IDX_RESET)) begin
                read_len <= resp_i.data;
            end
        end
    end

    assign read_done = byte_done && (state == ST_READ) && (idx >= IDX_LEN) && ((idx - IDX_LEN) >= read_len);

    // ready for a command after reset
    // cleared by a command, set by a reply
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            can_send <= 1'b1;
        end else if (reply_ready_i) begin
            can_send <= 1'b1;
        end else if (cmd_valid_o && cmd_o.last) begin
            can_send <= 1'b0;
        end
    end

    // interrupt held until the response is read
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reply_irq_n_o <= 1'b1;
        end else if (reply_ready_i) begin
            reply_irq_n_o <= 1'b0;
        end else if (read_done) begin
            reply_irq_n_o <= 1'b1;
        end
    end

    always_comb begin
        flags = 8'h00;
        flags[FLAG_READ_BIT] = !reply_irq_n_o;
        flags[FLAG_SEND_BIT] = can_send;
    end

    always_comb begin
        load = 1'b0;
        next_tx = 8'h00;
        if (byte_done) begin
            if ((state == ST_POLL) || ((state == ST_CTRL) && (rx_byte == CTRL_POLL))) begin
                load = 1'b1;
                next_tx = flags;
            end else if ((state == ST_READ) || ((state == ST_CTRL) && (rx_byte == CTRL_READ))) begin
                load = 1'b1;
                next_tx = resp_i.valid ? resp_i.data : 8'h00;
            end
        end
    end

    // The response stream is consumed only while a read is in progress.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            resp_take_o <= 1'b0;
        end else begin
            resp_take_o <= load && resp_i.valid && (state != ST_POLL) && (rx_byte != CTRL_POLL || state != ST_CTRL);
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_sh <= 8'h00;
            spi_miso_o <= 1'b0;
        end else if (!active) begin
            tx_sh <= 8'h00;
            spi_miso_o <= 1'b0;
        end else if (load) begin
            tx_sh <= next_tx;
        end else if (sck_fall) begin
            spi_miso_o <= tx_sh[7];
            tx_sh <= {tx_sh[6:0], 1'b0};
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            spi_miso_oe_o <= 1'b0;
        end else begin
            spi_miso_oe_o <= active;
        end
    end

    // reset waits for select to rise
    // wait state left on wake low
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_reset_o <= 1'b0;
            wait_state_o <= 1'b0;
        end else begin
            ctrl_reset_o <= sel_rise && (state == ST_RESET);
            if (sel_rise && (state == ST_RESET)) begin
                wait_state_o <= 1'b1;
            end else if (!wake_s2) begin
                wait_state_o <= 1'b0;
            end
        end
    end

    chk_deselect_release: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        sel_s2 |=> !spi_miso_oe_o) else $error("Output enabled while deselected.");
    chk_flag_read_bit: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (load && next_tx == flags) |=> (tx_sh[3] == $past(!reply_irq_n_o)) && (tx_sh[7:4] == 4'h0))
        else $error("Flag read bit wrong.");
    chk_flag_send_bit: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (cmd_valid_o && cmd_o.last && !reply_ready_i) |=> !can_send) else $error("Send flag not cleared.");
    chk_rise_sample: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        cmd_valid_o |-> $past(sck_rise)) else $error("Byte taken off a rising edge.");
    chk_msb_shift: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (active && sck_fall && !load) |=> spi_miso_o == $past(tx_sh[7])) else $error("Output bit order wrong.");
    chk_reset_on_rise: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ctrl_reset_o |-> $past(sel_rise) && wait_state_o) else $error("Reset not tied to select rise.");
    chk_wake_exit: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (wait_state_o && !wake_s2 && !ctrl_reset_o && !sel_rise) |=> !wait_state_o) else $error("Wake ignored.");
    chk_irq_hold: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (!reply_irq_n_o && !read_done) |=> !reply_irq_n_o) else $error("Interrupt released early.");
    chk_echo_single: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (cmd_valid_o && cmd_o.first && cmd_o.data == CODE_ECHO) |-> cmd_o.last) else $error("Echo not single byte.");

endmodule // nhp_host_port

/* rtl/nhp_pkg.sv */
package nhp_pkg;

    // Control byte that opens every select-low period.
    localparam logic [7:0] CTRL_SEND = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h01;
    localparam logic [7:0] CTRL_READ = 8'h02;
    localparam logic [7:0] CTRL_POLL = 8'h03;

    // Positions inside the polled flag byte.
    localparam int FLAG_READ_BIT = 3;
    localparam int FLAG_SEND_BIT = 2;

    // Command codes seen as the first byte of a host frame.
    localparam logic [7:0] CODE_IDENTIFY = 8'h01;
    localparam logic [7:0] CODE_PROTOCOL = 8'h02;
    localparam logic [7:0] CODE_PRESENCE = 8'h03;
    localparam logic [7:0] CODE_LISTEN = 8'h05;
    localparam logic [7:0] CODE_TRANSMIT = 8'h06;
    localparam logic [7:0] CODE_WAIT_EVENT = 8'h07;
    localparam logic [7:0] CODE_FETCH = 8'h08;
    localparam logic [7:0] CODE_STORE = 8'h09;
    localparam logic [7:0] CODE_FILTER = 8'h0d;
    localparam logic [7:0] CODE_ECHO = 8'h55;

    localparam logic [7:0] MAX_PAYLOAD = 8'hfd;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [7:0] IDX_RESET = 8'h00;
    localparam logic [7:0] IDX_LEN = 8'h01;
    localparam logic [7:0] IDX_PAYLOAD = 8'h02;

    typedef enum logic [3:0] {
        CMD_IDENTIFY = 4'h1,
        CMD_PROTOCOL = 4'h2,
        CMD_PRESENCE = 4'h3,
        CMD_LISTEN = 4'h5,
        CMD_TRANSMIT = 4'h6,
        CMD_WAIT_EVENT = 4'h7,
        CMD_FETCH = 4'h8,
        CMD_STORE = 4'h9,
        CMD_FILTER = 4'hd,
        CMD_ECHO = 4'he,
        CMD_RESERVED = 4'hf
    } nhp_cmd_e;

    typedef enum logic [5:0] {
        ST_CTRL = 6'h01,
        ST_SEND = 6'h02,
        ST_POLL = 6'h04,
        ST_READ = 6'h08,
        ST_RESET = 6'h10,
        ST_IGNORE = 6'h20
    } nhp_state_e;

    // One received command-frame byte with its frame position marks.
    typedef struct packed {
        logic first;
        logic last;
        logic [7:0] data;
    } nhp_cmd_byte_s;

    // One response byte offered by the controller.
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } nhp_resp_s;

endpackage

/* dv/nhp_host_model.sv */
`timescale 1ns/1ps
module nhp_host_model (
    input wire logic mclk_i,
    input wire logic miso_i,
    input wire logic miso_oe_i,
    output logic sck_o,
    output logic mosi_o,
    output logic sel_n_o
);
    logic line;
    // A released output reads as the inverse of its last level, so a stale bit never passes as data.
    assign line = miso_oe_i ? miso_i : ~miso_i;
    initial begin
        sck_o = 1'b0;
        mosi_o = 1'b0;
        sel_n_o = 1'b1;
    end
    task automatic half();
        repeat (4) @(posedge mclk_i);
        #1;
    endtask
    task automatic select(input logic low);
        half();
        sel_n_o = ~low;
        if (!low) begin
            mosi_o = ~mosi_o;
        end
        half();
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi_o = tx[i];
            half();
            sck_o = 1'b1;
            rx[i] = line;
            half();
            sck_o = 1'b0;
        end
    endtask
endmodule // nhp_host_model

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import nhp_pkg::*;
    logic mclk_i, rstn_i, spi_sck_i, spi_mosi_i, host_sel_n_i, wake_n_i, sleep_i, reply_ready_i;
    logic spi_miso_o, spi_miso_oe_o, reply_irq_n_o, cmd_valid_o, resp_take_o, ctrl_reset_o, wait_state_o;
    logic take;
    nhp_resp_s resp_i;
    nhp_cmd_byte_s cmd_o;
    nhp_cmd_e cmd_kind_o;
    int error_cnt, checks_done, cycles, oe_cnt, rst_cnt;
    integer seed;
    logic [7:0] rq[$];
    nhp_cmd_byte_s cq[$];
    localparam logic [7:0] CODES [12] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0d, 8'h55,
        8'h04, 8'hfe};

    nhp_host_port uut (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .spi_sck_i(spi_sck_i),
        .spi_mosi_i(spi_mosi_i),
        .host_sel_n_i(host_sel_n_i),
        .wake_n_i(wake_n_i),
        .sleep_i(sleep_i),
        .reply_ready_i(reply_ready_i),
        .resp_i(resp_i),
        .spi_miso_o(spi_miso_o),
        .spi_miso_oe_o(spi_miso_oe_o),
        .reply_irq_n_o(reply_irq_n_o),
        .cmd_o(cmd_o),
        .cmd_valid_o(cmd_valid_o),
        .cmd_kind_o(cmd_kind_o),
        .resp_take_o(resp_take_o),
        .ctrl_reset_o(ctrl_reset_o),
        .wait_state_o(wait_state_o)
    );
    nhp_host_model host (
        .mclk_i(mclk_i),
        .miso_i(spi_miso_o),
        .miso_oe_i(spi_miso_oe_o),
        .sck_o(spi_sck_i),
        .mosi_o(spi_mosi_i),
        .sel_n_o(host_sel_n_i)
    );

    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    // The response source advances one cycle after each take, as the controller would.
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 40000) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: timeout", $time);
            test_done();
        end else begin
            if (spi_miso_oe_o === 1'b1) oe_cnt++;
            if (ctrl_reset_o === 1'b1) rst_cnt++;
            if (cmd_valid_o === 1'b1) cq.push_back(cmd_o);
            take = resp_take_o;
            #1;
            if (take === 1'b1 && rq.size() > 0) void'(rq.pop_front());
            resp_i.valid = (rq.size() != 0);
            resp_i.data = resp_i.valid ? rq[0] : 8'h00;
        end
    end

    function automatic logic [7:0] rand8();
        return 8'($random(seed));
    endfunction

    function automatic logic [3:0] kind_of(input logic [7:0] c);
        case (c)
            8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0d: kind_of = c[3:0];
            8'h55: kind_of = 4'he;
            default: kind_of = 4'hf;
        endcase
    endfunction

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic poll(input logic [7:0] exp);
        logic [7:0] rx;
        host.select(1'b1);
        host.xfer(CTRL_POLL, rx);
        chk_bit(spi_miso_oe_o, 1'b1, "driving");
        repeat (2) begin
            host.xfer(rand8(), rx);
            chk_byte(rx & 8'h0c, exp, "flags");
        end
        host.select(1'b0);
        tick(4);
        chk_bit(spi_miso_oe_o, 1'b0, "released");
    endtask

    task automatic exchange(input logic [7:0] code);
        logic [7:0] rx;
        logic [7:0] len;
        logic [7:0] frame[$];
        logic [7:0] resp[$];
        frame = {code};
        if (code != CODE_ECHO) begin
            len = rand8() % 8'h04;
            frame.push_back(len);
            repeat (len) frame.push_back(rand8());
        end
        cq.delete();
        host.select(1'b1);
        host.xfer(CTRL_SEND, rx);
        foreach (frame[i]) host.xfer(frame[i], rx);
        host.select(1'b0);
        chk_byte(8'(cq.size()), 8'(frame.size()), "frame size");
        for (int i = 0; i < cq.size() && i < frame.size(); i++) begin
            chk_byte(cq[i].data, frame[i], "cmd byte");
            chk_bit(cq[i].first, i == 0, "first mark");
            chk_bit(cq[i].last, i == frame.size() - 1, "last mark");
        end
        chk_byte({4'h0, cmd_kind_o}, {4'h0, kind_of(code)}, "kind");
        poll(8'h00);
        len = rand8() % 8'h04;
        resp = {rand8(), len};
        repeat (len) resp.push_back(rand8());
        rq = resp;
        reply_ready_i = 1'b1;
        tick(1);
        reply_ready_i = 1'b0;
        tick(3);
        chk_bit(reply_irq_n_o, 1'b0, "irq set");
        poll(8'h0c);
        host.select(1'b1);
        host.xfer(CTRL_READ, rx);
        foreach (resp[i]) begin
            host.xfer(rand8(), rx);
            chk_byte(rx, resp[i], "resp byte");
        end
        host.select(1'b0);
        chk_bit(reply_irq_n_o, 1'b1, "irq clear");
        $display("test code %h done", code);
    endtask

    initial begin
        logic [7:0] rx;
        seed = 32'hf6dadf33;
        rstn_i = 1'b0;
        wake_n_i = 1'b1;
        sleep_i = 1'b0;
        reply_ready_i = 1'b0;
        repeat (3) @(posedge mclk_i);
        #1;
        rstn_i = 1'b1;
        tick(4);
        chk_bit(spi_miso_oe_o, 1'b0, "oe idle");
        chk_bit(reply_irq_n_o, 1'b1, "irq idle");
        chk_byte({4'h0, cmd_kind_o}, 8'h0f, "kind idle");
        poll(8'h04);
        $display("test reset done");
        foreach (CODES[i]) exchange(CODES[i]);
        sleep_i = 1'b1;
        oe_cnt = 0;
        cq.delete();
        host.select(1'b1);
        host.xfer(CTRL_SEND, rx);
        host.xfer(CODE_IDENTIFY, rx);
        host.xfer(8'h00, rx);
        host.select(1'b0);
        chk_bit(cq.size() == 0 && oe_cnt == 0, 1'b1, "asleep");
        sleep_i = 1'b0;
        cq.delete();
        host.select(1'b1);
        host.xfer(8'h80 | rand8(), rx);
        host.xfer(CODE_IDENTIFY, rx);
        host.xfer(8'h00, rx);
        host.select(1'b0);
        chk_bit(cq.size() == 0, 1'b1, "bad control ignored");
        $display("test sleep done");
        rst_cnt = 0;
        host.select(1'b1);
        host.xfer(CTRL_RESET, rx);
        tick(8);
        chk_bit(rst_cnt == 0, 1'b1, "reset held");
        host.select(1'b0);
        tick(4);
        chk_bit(rst_cnt == 1, 1'b1, "reset pulse");
        chk_bit(wait_state_o, 1'b1, "waiting");
        oe_cnt = 0;
        host.select(1'b1);
        host.xfer(CTRL_POLL, rx);
        host.select(1'b0);
        chk_bit(oe_cnt == 0, 1'b1, "wait quiet");
        wake_n_i = 1'b0;
        tick(6);
        chk_bit(wait_state_o, 1'b0, "woken");
        $display("test serial reset done");
        test_done();
    end
endmodule // testbench
